// ===== verilog/sccc_consts.svh
// Purpose: constants for the sysref capture clock control block
// Assumes: byte-wide registers on a plain strobe port
// Notes:   offsets are the printed register addresses
`ifndef SCCC_CONSTS_SVH
`define SCCC_CONSTS_SVH
`define SCCC_ADDR_W          10
`define SCCC_OFF_CTRL0       10'h030
`define SCCC_OFF_STATUS      10'h031
`define SCCC_OFF_CTRL2       10'h032
`define SCCC_OFF_ANAMISC     10'h033
`define SCCC_OFF_CLAMP       10'h034
`define SCCC_OFF_RSVA        10'h035
`define SCCC_OFF_RSVB        10'h036
`define SCCC_OFF_RSVC        10'h037
`define SCCC_OFF_IRQ_STAT    10'h038
`define SCCC_OFF_IRQ_MASK    10'h039
`define SCCC_OFF_SOFTRST     10'h021
`define SCCC_RST_CTRL0       8'hc0
`define SCCC_RST_CTRL2       8'h80
`define SCCC_RST_ANAMISC     8'hc3
`define SCCC_RST_CLAMP       8'h2f
`define SCCC_RST_RSVA        8'hdf
`define SCCC_RST_RSVB        8'h00
`define SCCC_RST_RSVC        8'h45
`define SCCC_STATUS_LOW      6'h07
`define SCCC_BIT_RCVR_EN     7
`define SCCC_BIT_PROC_EN     6
`define SCCC_BIT_SEEN_CLR    5
`define SCCC_BIT_DIRTY_CLR   4
`define SCCC_BIT_CLK_DC      2
`define SCCC_BIT_SYSREF_DC   1
`define SCCC_BIT_SYNC_DC     0
`define SCCC_BIT_SYNC_PD     2
`define SCCC_DELAY_STEP_PS   20
`define SCCC_DELAY_MAX       4'hf
`define SCCC_CLK_PERIOD_PS   10000
`endif

// ===== verilog/sccc_pkg.sv
// Purpose: shared types for the sysref capture clock control block
// Assumes: field widths and edge codes are written out here, not taken from sccc_consts.svh
// Notes:   types only
package sccc_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [9:0] addr;
    logic [7:0] wdata;
  } sccc_bus_s;

  typedef struct packed {
    logic       receiver_enable;
    logic       processor_enable;
    logic       device_clock_input_dc;
    logic       sysref_dc;
    logic       sync_dc;
    logic       sync_pd;
    logic [3:0] delay_steps;
  } sccc_ctl_s;

  typedef enum logic [1:0] {
    SCCC_EDGE_IDLE  = 2'b00,
    SCCC_EDGE_CLEAN = 2'b01,
    SCCC_EDGE_DIRTY = 2'b10
  } sccc_edge_e;
endpackage

// ===== verilog/sccc_edge_detect.sv
// Purpose: sysref sampler, rising edge and marginal capture detector
// Assumes: sysref is asynchronous to clk
// Notes:   dirty when a rise is sampled once but never settles high
`timescale 1ns/1ps
`include "sccc_consts.svh"
module sccc_edge_detect (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rstn,
  // control
  input  wire logic              enable,
  // sysref pin
  input  wire logic              sysref_in,
  // events
  output sccc_pkg::sccc_edge_e   edge_evt
);
  import sccc_pkg::*;

  typedef struct packed {
    logic [2:0] sync;
    logic       settled;
    sccc_edge_e evt;
  } sccc_edet_s;

  sccc_edet_s st_r;
  sccc_edet_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.sync = {st_r.sync[1:0], sysref_in};
    st_nxt.evt = SCCC_EDGE_IDLE;
    // change counts once stages two and three agree
    if (st_r.sync[2] == st_r.sync[1]) begin
      st_nxt.settled = st_r.sync[2];
      if (enable && st_r.sync[2] && !st_r.settled) begin
        st_nxt.evt = SCCC_EDGE_CLEAN;
      end
    end else if (enable && st_r.sync[2] && !st_r.sync[1] &&
                 !st_r.settled) begin
      // rise caught by one sample only, gone before stages agree:
      // timing was not ensured, so it counts as a dirty capture
      st_nxt.evt = SCCC_EDGE_DIRTY;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_r <= '{sync: 3'h0, settled: 1'b0, evt: SCCC_EDGE_IDLE};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign edge_evt = st_r.evt;
endmodule // sccc_edge_detect

// ===== verilog/sccc_top.sv
// Purpose: sysref capture clock control and status registers
// Assumes: 100 MHz clk, synchronous active low rstn, strobe register port
// Notes:   analog controls leave as registered levels
`timescale 1ns/1ps
`include "sccc_consts.svh"
module sccc_top #(
  parameter int DELAY_STEP_PS = `SCCC_DELAY_STEP_PS
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rstn,
  // register port
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [9:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  output logic      [7:0]        reg_rdata,
  // sysref pin
  input  wire logic              sysref_in,
  // controls to the analog front end
  output sccc_pkg::sccc_ctl_s    ctl,
  // interrupt
  output logic                   irq
);
  import sccc_pkg::*;

  initial begin
    if (DELAY_STEP_PS < 1) begin
      $error("delay step must be positive");
    end
  end

  typedef struct packed {
    logic [7:0] ctrl0;
    logic [7:0] ctrl2;
    logic [7:0] anamisc;
    logic [7:0] clamp;
    logic [7:0] rsva;
    logic [7:0] rsvb;
    logic [7:0] rsvc;
    logic       softrst;
    logic       seen;
    logic       dirty;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [7:0] rdata;
    sccc_ctl_s  ctl;
    logic       irq;
  } sccc_state_s;

  sccc_state_s st_r;
  sccc_state_s st_nxt;
  sccc_bus_s   bus;
  sccc_edge_e  edge_evt;
  logic        soft_kick;

  localparam sccc_state_s RESET_ST = '{
    ctrl0:    `SCCC_RST_CTRL0,
    ctrl2:    `SCCC_RST_CTRL2,
    anamisc:  `SCCC_RST_ANAMISC,
    clamp:    `SCCC_RST_CLAMP,
    rsva:     `SCCC_RST_RSVA,
    rsvb:     `SCCC_RST_RSVB,
    rsvc:     `SCCC_RST_RSVC,
    softrst:  1'b0,
    seen:     1'b0,
    dirty:    1'b0,
    irq_stat: 2'h0,
    irq_mask: 2'h0,
    rdata:    8'h00,
    ctl:      '{receiver_enable: 1'b1, processor_enable: 1'b1,
                device_clock_input_dc: 1'b0, sysref_dc: 1'b0, sync_dc: 1'b0,
                sync_pd: 1'b0, delay_steps: 4'h0},
    irq:      1'b0
  };

  function automatic logic hit(input logic [9:0] a, input logic [9:0] off);
    hit = (a == off);
  endfunction

  function automatic sccc_ctl_s ctl_of(input logic [7:0] c0,
                                       input logic [7:0] c2,
                                       input logic [7:0] am);
    ctl_of.receiver_enable  = c0[`SCCC_BIT_RCVR_EN];
    ctl_of.processor_enable = c0[`SCCC_BIT_PROC_EN];
    ctl_of.device_clock_input_dc        = c0[`SCCC_BIT_CLK_DC];
    ctl_of.sysref_dc        = c0[`SCCC_BIT_SYSREF_DC];
    ctl_of.sync_dc          = c0[`SCCC_BIT_SYNC_DC];
    ctl_of.sync_pd          = am[`SCCC_BIT_SYNC_PD];
    ctl_of.delay_steps      = c2[3:0];
  endfunction

  assign bus = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

  // edges are seen only while both receiver and processor run;
  // the power sequencing itself is software's duty
  sccc_edge_detect u_edge (
    .clk       (clk),
    .rstn      (rstn),
    .enable    (st_r.ctl.receiver_enable & st_r.ctl.processor_enable),
    .sysref_in (sysref_in),
    .edge_evt  (edge_evt)
  );

  // soft reset acts on the 0 to 1 transition only, bit is not self clearing
  assign soft_kick = bus.wr && hit(bus.addr, `SCCC_OFF_SOFTRST) &&
                     bus.wdata[0] && !st_r.softrst;

  always_comb begin
    logic seen_set;
    logic dirty_set;
    logic [7:0] status;
    seen_set  = 1'b0;
    dirty_set = 1'b0;
    status    = 8'h00;
    st_nxt = st_r;
    // flags held clear while clear bit high, then may set
    seen_set  = (edge_evt != SCCC_EDGE_IDLE) &&
                !st_r.ctrl0[`SCCC_BIT_SEEN_CLR];
    // only a ringing sampler is caught; a clean sweep jump is not
    dirty_set = (edge_evt == SCCC_EDGE_DIRTY) &&
                !st_r.ctrl0[`SCCC_BIT_DIRTY_CLR];
    if (st_r.ctrl0[`SCCC_BIT_SEEN_CLR]) begin
      st_nxt.seen = 1'b0;
    end else if (seen_set) begin
      st_nxt.seen = 1'b1;
    end
    if (st_r.ctrl0[`SCCC_BIT_DIRTY_CLR]) begin
      st_nxt.dirty = 1'b0;
    end else if (dirty_set) begin
      st_nxt.dirty = 1'b1;
    end
    status = {st_r.seen, st_r.dirty, `SCCC_STATUS_LOW};
    // read data valid only in the cycle after the strobe
    st_nxt.rdata = 8'h00;
    if (bus.rd) begin
      unique case (1'b1)
        hit(bus.addr, `SCCC_OFF_CTRL0):    st_nxt.rdata = st_r.ctrl0;
        hit(bus.addr, `SCCC_OFF_STATUS):   st_nxt.rdata = status;
        hit(bus.addr, `SCCC_OFF_CTRL2):    st_nxt.rdata = st_r.ctrl2;
        hit(bus.addr, `SCCC_OFF_ANAMISC):  st_nxt.rdata = st_r.anamisc;
        hit(bus.addr, `SCCC_OFF_CLAMP):    st_nxt.rdata = st_r.clamp;
        hit(bus.addr, `SCCC_OFF_RSVA):     st_nxt.rdata = st_r.rsva;
        hit(bus.addr, `SCCC_OFF_RSVB):     st_nxt.rdata = st_r.rsvb;
        hit(bus.addr, `SCCC_OFF_RSVC):     st_nxt.rdata = st_r.rsvc;
        hit(bus.addr, `SCCC_OFF_SOFTRST):
          st_nxt.rdata = {7'h00, st_r.softrst};
        hit(bus.addr, `SCCC_OFF_IRQ_STAT):
          st_nxt.rdata = {6'h00, st_r.irq_stat};
        hit(bus.addr, `SCCC_OFF_IRQ_MASK):
          st_nxt.rdata = {6'h00, st_r.irq_mask};
        default:                           st_nxt.rdata = 8'h00;
      endcase
    end
    // sticky interrupt status, cleared by a read, a new event wins
    if (bus.rd && hit(bus.addr, `SCCC_OFF_IRQ_STAT)) begin
      st_nxt.irq_stat = 2'h0;
    end
    st_nxt.irq_stat = st_nxt.irq_stat | {dirty_set, seen_set};
    if (bus.wr) begin
      unique case (1'b1)
        hit(bus.addr, `SCCC_OFF_CTRL0):    st_nxt.ctrl0   = bus.wdata;
        hit(bus.addr, `SCCC_OFF_CTRL2):    st_nxt.ctrl2   = bus.wdata;
        hit(bus.addr, `SCCC_OFF_ANAMISC):  st_nxt.anamisc = bus.wdata;
        hit(bus.addr, `SCCC_OFF_CLAMP):    st_nxt.clamp   = bus.wdata;
        hit(bus.addr, `SCCC_OFF_RSVA):     st_nxt.rsva    = bus.wdata;
        hit(bus.addr, `SCCC_OFF_RSVB):     st_nxt.rsvb    = bus.wdata;
        hit(bus.addr, `SCCC_OFF_RSVC):     st_nxt.rsvc    = bus.wdata;
        hit(bus.addr, `SCCC_OFF_SOFTRST):  st_nxt.softrst = bus.wdata[0];
        hit(bus.addr, `SCCC_OFF_IRQ_MASK):
          st_nxt.irq_mask = bus.wdata[1:0];
        default:                           st_nxt.rsva    = st_r.rsva;
      endcase
    end
    st_nxt.ctl = ctl_of(st_nxt.ctrl0, st_nxt.ctrl2, st_nxt.anamisc);
    st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);
    if (soft_kick) begin
      // all registers back to defaults, the reset bit keeps its new 1; u_edge is not reset
      st_nxt = RESET_ST;
      st_nxt.softrst = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_r <= RESET_ST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign ctl       = st_r.ctl;
  assign irq       = st_r.irq;
endmodule // sccc_top

// ===== test/sccc_top_sva.sv
// Purpose: port level checks of the clock control registers
// Assumes: bound to sccc_top, one clock domain
// Notes:   flags are only visible through status reads
`timescale 1ns/1ps
module sccc_top_sva #(
  parameter int DELAY_STEP_PS = 20
) (
  // clock and reset
  input wire logic                clk,
  input wire logic                rstn,
  // register port
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [9:0]          reg_addr,
  input wire logic [7:0]          reg_wdata,
  input wire logic [7:0]          reg_rdata,
  // pins
  input wire logic                sysref_in,
  input wire sccc_pkg::sccc_ctl_s ctl,
  input wire logic                irq
);
  import sccc_pkg::*;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence s_wr(logic [9:0] ad);
    reg_wr && reg_addr == ad;
  endsequence
  sequence s_clr(int b);
    s_wr(10'h030) ##0 reg_wdata[b];
  endsequence
  // gap cycle lets a registered clear bit reach the flag first
  property p_clr(int b, int f);
    s_clr(b) ##1 !reg_wr ##1 (reg_rd && reg_addr == 10'h031)
      |=> !reg_rdata[f];
  endproperty
  a_status_low: assert property (
    reg_rd && reg_addr == 10'h031 |=> reg_rdata[5:0] == 6'h07)
    else $error("status low bits wrong");
  a_rcvr_write: assert property (
    s_wr(10'h030) |=> ctl.receiver_enable == $past(reg_wdata[7]))
    else $error("receiver enable not written");
  a_proc_write: assert property (
    s_wr(10'h030) |=> ctl.processor_enable == $past(reg_wdata[6]))
    else $error("processor enable not written");
  a_term_write: assert property (
    $past(reg_wr) && $past(reg_addr) == 10'h030 |->
      {ctl.device_clock_input_dc, ctl.sysref_dc, ctl.sync_dc} == $past(reg_wdata[2:0]))
    else $error("termination selects not written");
  a_delay_write: assert property (
    s_wr(10'h032) |=> ctl.delay_steps == $past(reg_wdata[3:0]))
    else $error("delay steps not written");
  a_sync_pd: assert property (
    $past(reg_wr) && $past(reg_addr) == 10'h033 |->
      ctl.sync_pd == $past(reg_wdata[2]))
    else $error("sync powerdown not written");
  a_seen_clear: assert property (p_clr(5, 7))
    else $error("seen flag not held clear");
  a_dirty_clear: assert property (p_clr(4, 6))
    else $error("dirty flag not held clear");
endmodule // sccc_top_sva
bind sccc_top sccc_top_sva #(.DELAY_STEP_PS(DELAY_STEP_PS)) u_sva (
  .clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .sysref_in(sysref_in), .ctl(ctl), .irq(irq));

// ===== test/sccc_sysref_gen.sv
// Purpose: behavioural clock source giving sysref pulses
// Assumes: one pulse for each rise of fire, off the clk edge
// Notes:   sysref idles low; narrow gives a pulse seen by one edge only
`timescale 1ns/1ps
module sccc_sysref_gen (
  // control
  input  wire logic clk,
  input  wire logic fire,
  input  wire logic narrow,
  // pin
  output logic      sysref
);
  initial sysref = 1'b0;
  always @(posedge fire) begin
    #3.3 sysref = 1'b1;
    if (narrow) begin
      #8 sysref = 1'b0;
    end else begin
      repeat (6) @(posedge clk);
      #2.7 sysref = 1'b0;
    end
  end
endmodule // sccc_sysref_gen

// ===== test/sccc_top_tb.sv
// Purpose: self-checking bench for the clock control block
// Assumes: strobe register port, sysref from the source model
// Notes:   source pulses are clean unless narrow asks for a dirty one
`timescale 1ns/1ps
module sccc_top_tb;
  import sccc_pkg::*;
  logic        clk, rstn, reg_wr, reg_rd, fire, sysref_in, irq, narrow;
  logic [9:0]  reg_addr, a;
  logic [7:0]  reg_wdata, reg_rdata, d;
  logic [31:0] r, seed;
  logic [7:0]  mdl [8];
  sccc_ctl_s   ctl;
  int          n_errors, samples_checked;
  sccc_top DUT (.clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .sysref_in(sysref_in), .ctl(ctl), .irq(irq));
  sccc_sysref_gen SRC (.clk(clk), .fire(fire), .narrow(narrow),
    .sysref(sysref_in));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [9:0] ectl();
    return {mdl[0][7:6], mdl[0][2:0], mdl[3][2], mdl[2][3:0]};
  endfunction
  task automatic mreset();
    mdl = '{8'hc0, 8'h07, 8'h80, 8'hc3, 8'h2f, 8'hdf, 8'h00, 8'h45};
  endtask
  task automatic chk_rd(input string n, input logic [7:0] e, g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_ctl(input logic [9:0] e);
    #1;
    samples_checked++;
    if (ctl !== e) begin
      n_errors++;
      $display("mismatch ctl expected %h seen %h", e, ctl);
    end
  endtask
  task automatic wr(input logic [9:0] ad, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (ad != 10'h031 && ad[9:3] == 7'h06) mdl[ad[2:0]] = v;
  endtask
  task automatic rd(input logic [9:0] ad, output logic [7:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic rc(input logic [9:0] ad, input logic [7:0] e, m);
    logic [7:0] v;
    rd(ad, v);
    chk_rd($sformatf("reg %h", ad), e & m, v & m);
  endtask
  task automatic rall();
    for (a = 10'h030; a < 10'h038; a++) rc(a, mdl[a[2:0]], 8'hff);
  endtask
  task automatic pulse();
    @(posedge clk);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
  endtask
  task automatic wirq(input logic v);
    for (int k = 0; k < 40 && irq !== v; k++) @(posedge clk);
    #1 chk_rd("irq", {7'h0, v}, {7'h0, irq});
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard, well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end
  initial begin
    {rstn, reg_wr, reg_rd, fire, narrow, reg_addr, reg_wdata} = '0;
    seed = 32'd4494;
    mreset();
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    rall();
    chk_ctl(ectl());
    wr(10'h03a, 8'hff);
    rc(10'h03a, 8'h00, 8'hff);
    $display("test reset done");
    repeat (4) begin
      for (a = 10'h030; a < 10'h038; a++) begin
        r = xs();
        // enables keep their state here: power order is tested apart
        wr(a, a == 10'h030 ? (r[7:0] & 8'h0f) | (mdl[0] & 8'hc0)
                           : r[7:0]);
      end
      chk_ctl(ectl());
      rall();
    end
    $display("test random done");
    wr(10'h030, mdl[0] & 8'hbf);
    chk_ctl(ectl());
    wr(10'h030, mdl[0] & 8'h7f);
    chk_ctl(ectl());
    wr(10'h030, mdl[0] | 8'h80);
    chk_ctl(ectl());
    wr(10'h030, mdl[0] | 8'h40);
    chk_ctl(ectl());
    $display("test power done");
    wr(10'h039, 8'h01);
    pulse();
    wirq(1'b1);
    mdl[1][7] = 1'b1;
    rc(10'h031, mdl[1], 8'hff);
    rc(10'h031, mdl[1], 8'hff);
    rc(10'h038, 8'h01, 8'h03);
    rc(10'h038, 8'h00, 8'h03);
    wirq(1'b0);
    wr(10'h030, mdl[0] | 8'h30);
    mdl[1] = 8'h07;
    rc(10'h031, mdl[1], 8'hff);
    pulse();
    repeat (12) @(posedge clk);
    rc(10'h031, mdl[1], 8'hff);
    wr(10'h030, mdl[0] & 8'hcf);
    rc(10'h031, mdl[1], 8'hff);
    wr(10'h039, 8'h00);
    rd(10'h038, d);
    pulse();
    repeat (12) @(posedge clk);
    wirq(1'b0);
    mdl[1][7] = 1'b1;
    rc(10'h031, mdl[1], 8'hff);
    $display("test sysref done");
    rc(10'h038, 8'h01, 8'hff);
    narrow <= 1'b1;
    wr(10'h039, 8'h02);
    pulse();
    wirq(1'b1);
    mdl[1][6] = 1'b1;
    rc(10'h031, mdl[1], 8'hff);
    rc(10'h038, 8'h03, 8'hff);
    wr(10'h030, mdl[0] | 8'h10);
    wr(10'h030, mdl[0] & 8'hef);
    mdl[1][6] = 1'b0;
    rc(10'h031, mdl[1], 8'hff);
    narrow <= 1'b0;
    $display("test dirty done");
    wr(10'h021, 8'h01);
    mreset();
    repeat (2) @(posedge clk);
    rall();
    chk_ctl(ectl());
    rc(10'h021, 8'h01, 8'h01);
    wr(10'h021, 8'h00);
    $display("test softreset done");
    report_and_stop();
  end
endmodule // sccc_top_tb
